// ==== hdl/sfrsp_core.sv ====
/*
 * Special register space decode with stack pointer and data memory.
 * Assumes one request per cycle from execution logic on the same clock;
 * the answer appears one cycle after the request.
 */
// Behaviour
// - A stack top pointer at special address 0x81 names the last push.
// - A push writes memory at pointer plus one, then advances the pointer.
// - Reset loads the pointer with 0x07 so the first push lands at 0x08.
// - The stack may span all 256 bytes; pointer steps wrap at 8 bits.
// - Direct accesses to 0x80 through 0xFF go to the special space.
// - Registers at addresses ending in 0x0 or 0x8 take bit accesses.
// - Other registers take byte accesses only; no bit address maps there.
// - Each implemented register sits at its fixed map address.
// - Indirect accesses above 0x7F reach upper memory, never registers.
`timescale 1ns/1ps

module sfrsp_core #(
    parameter int MEM_DEPTH = 256
) (
    input  wire logic                sys_clk,
    input  wire logic                arst_n,
    input  wire sfrsp_pkg::sfrsp_req_t req,
    output sfrsp_pkg::sfrsp_rsp_t    rsp,
    output logic [7:0]               stack_top_pointer,
    output logic [7:0]               accumulator_register
);

    // row head only
    // Bit address to byte address: a high bit address names the first
    // column of its row in the special space, a low one a byte of 0x20..0x2F
    function automatic logic [7:0] bit_byte(input logic [7:0] baddr);
        if (baddr[7]) begin
            bit_byte = {baddr[7:3], sfrsp_pkg::BIT_ROW_COL};
        end else begin
            bit_byte = {4'h2, baddr[6:3]};
        end
    endfunction

    // Byte with one bit replaced
    function automatic logic [7:0] set_bit(input logic [7:0] v,
                                           input logic [2:0] pos,
                                           input logic       b);
        logic [7:0] r;
        r = v;
        r[pos] = b;
        set_bit = r;
    endfunction

    // wrap at 8 bits
    // Pointer step; the cast keeps the sum inside the 8-bit address so the
    // stack runs round from 0xFF to 0x00 and back
    function automatic logic [7:0] ptr_add(input logic [7:0] p,
                                           input logic [7:0] d);
        ptr_add = 8'(p + d);
    endfunction

    // True where a register stands behind a special address; the rest of
    // the space is reserved
    function automatic logic reg_known(input logic [7:0] addr);
        case (addr)
            sfrsp_pkg::STACK_PTR_ADDR,
            sfrsp_pkg::ACCUMULATOR_ADDR,
            sfrsp_pkg::B_REG_ADDR: reg_known = 1'b1;
            default:               reg_known = 1'b0;
        endcase
    endfunction

    // Internal data memory; indirect and stack accesses always land here
    logic [7:0] mem [MEM_DEPTH];

    // Registers of the special space and the registered answer
    logic [7:0]              ptr_reg, ptr_next;
    logic [7:0]              accum_reg, accum_next;
    logic [7:0]              b_reg, b_next;
    sfrsp_pkg::sfrsp_rsp_t   rsp_reg, rsp_next;

    // Memory write port signals
    logic       mem_we;
    logic [7:0] mem_waddr;
    logic [7:0] mem_wdata;

    // Decode of the request in hand
    logic [7:0] byte_addr;
    logic       is_special;
    logic [7:0] cur_byte;
    logic [7:0] wval;

    // Next-state logic for registers, memory write and answer
    always_comb begin
        ptr_next   = ptr_reg;
        accum_next = accum_reg;
        b_next     = b_reg;
        rsp_next   = '0;
        mem_we     = 1'b0;
        mem_waddr  = 8'h00;
        mem_wdata  = 8'h00;
        byte_addr  = req.addr;
        is_special = 1'b0;
        cur_byte   = sfrsp_pkg::UNMAPPED_READ;
        wval       = req.wdata;

        // Bit accesses first become the address of the byte holding the bit
        if (req.kind == sfrsp_pkg::SFRSP_BIT) begin
            byte_addr = bit_byte(req.addr);
        end

        if (req.kind == sfrsp_pkg::SFRSP_DIRECT ||
            req.kind == sfrsp_pkg::SFRSP_BIT) begin
            is_special = byte_addr[7];
        end

        if (is_special) begin
            unique case (byte_addr)
                sfrsp_pkg::STACK_PTR_ADDR:   cur_byte = ptr_reg;
                sfrsp_pkg::ACCUMULATOR_ADDR: cur_byte = accum_reg;
                sfrsp_pkg::B_REG_ADDR:       cur_byte = b_reg;
                // Reserved addresses keep the zero set above
                default:                     ;
            endcase
        end else begin
            cur_byte = mem[byte_addr];
        end

        if (req.kind == sfrsp_pkg::SFRSP_BIT) begin
            wval = set_bit(cur_byte, req.addr[2:0], req.wbit);
        end

        // Per kind: answer, register write and memory write
        unique case (req.kind)
            sfrsp_pkg::SFRSP_DIRECT, sfrsp_pkg::SFRSP_BIT: begin
                rsp_next.valid       = 1'b1;
                rsp_next.rdata       = cur_byte;
                rsp_next.rbit        = cur_byte[req.addr[2:0]];
                rsp_next.special_hit = is_special;
                if (req.write && is_special) begin
                    unique case (byte_addr)
                        sfrsp_pkg::STACK_PTR_ADDR:   ptr_next   = wval;
                        sfrsp_pkg::ACCUMULATOR_ADDR: accum_next = wval;
                        sfrsp_pkg::B_REG_ADDR:       b_next     = wval;
                        default:                     ; // Reserved: dropped
                    endcase
                end else if (req.write) begin
                    mem_we    = 1'b1;
                    mem_waddr = byte_addr;
                    mem_wdata = wval;
                end
            end
            sfrsp_pkg::SFRSP_INDIRECT: begin
                rsp_next.valid = 1'b1;
                rsp_next.rdata = mem[req.addr];
                if (req.write) begin
                    mem_we    = 1'b1;
                    mem_waddr = req.addr;
                    mem_wdata = req.wdata;
                end
            end
            sfrsp_pkg::SFRSP_PUSH: begin
                mem_we         = 1'b1;
                mem_waddr      = ptr_add(ptr_reg, 8'h01);
                mem_wdata      = req.wdata;
                ptr_next       = ptr_add(ptr_reg, 8'h01);
                rsp_next.valid = 1'b1;
            end
            sfrsp_pkg::SFRSP_POP: begin
                // read then decrement
                // Reads the same array a push writes, so a pop right after a
                // push returns the byte just stacked
                rsp_next.valid = 1'b1;
                rsp_next.rdata = mem[ptr_reg];
                ptr_next       = ptr_add(ptr_reg, 8'hFF);
            end
            default: ; // No access this cycle
        endcase

        // A bit access into the special space only ever reaches a row head; flag it when no register
        // stands there, so the core knows the bit went nowhere
        if (req.kind == sfrsp_pkg::SFRSP_BIT && is_special &&
            !reg_known(byte_addr)) begin
            rsp_next.bit_error = 1'b1;
        end
    end

    // Register state; memory has no reset to keep it a plain RAM,
    // so its bytes are unknown until first written
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            ptr_reg   <= sfrsp_pkg::STACK_PTR_RESET;
            accum_reg <= sfrsp_pkg::ACCUMULATOR_RESET;
            b_reg     <= sfrsp_pkg::B_REG_RESET;
            rsp_reg   <= '0;
        end else begin
            ptr_reg   <= ptr_next;
            accum_reg <= accum_next;
            b_reg     <= b_next;
            rsp_reg   <= rsp_next;
        end
    end

    // Data memory write port; a read in the next cycle sees the new byte
    always_ff @(posedge sys_clk) begin
        if (mem_we) begin
            mem[mem_waddr] <= mem_wdata;
        end
    end

    // Outputs come straight from flip-flops
    assign rsp                  = rsp_reg;
    assign stack_top_pointer    = ptr_reg;
    assign accumulator_register = accum_reg;

endmodule // sfrsp_core

// ==== hdl/sfrsp_pkg.sv ====
/*
 * Package for the special register space decode and stack pointer block.
 * Assumes an 8-bit core data path and 256 bytes of internal data memory.
 */
package sfrsp_pkg;

    // Address and data widths
    localparam int ADDR_W = 8;
    localparam int DATA_W = 8;

    // Stack pointer location and reset value
    localparam logic [7:0] STACK_PTR_ADDR  = 8'h81;
    localparam logic [7:0] STACK_PTR_RESET = 8'h07;

    // Special register space begins here for direct accesses
    localparam logic [7:0] SPECIAL_BASE = 8'h80;

    // Other core registers placed in the map
    localparam logic [7:0] ACCUMULATOR_ADDR = 8'hE0;
    localparam logic [7:0] B_REG_ADDR       = 8'hF0;
    localparam logic [7:0] ACCUMULATOR_RESET = 8'h00;
    localparam logic [7:0] B_REG_RESET       = 8'h00;

    // Low three bits of a bit-addressable register address
    localparam logic [2:0] BIT_ROW_COL = 3'h0;

    // Value read back from an unmapped special address
    localparam logic [7:0] UNMAPPED_READ = 8'h00;

    // Access kinds issued by the core
    typedef enum logic [2:0] {
        SFRSP_NONE     = 3'b000,
        SFRSP_DIRECT   = 3'b001,
        SFRSP_INDIRECT = 3'b010,
        SFRSP_BIT      = 3'b011,
        SFRSP_PUSH     = 3'b100,
        SFRSP_POP      = 3'b101
    } sfrsp_kind_t;

    // One access request from the execution logic
    typedef struct packed {
        sfrsp_kind_t       kind;
        logic              write;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic              wbit;
    } sfrsp_req_t;

    // Answer to the execution logic
    typedef struct packed {
        logic              valid;
        logic [DATA_W-1:0] rdata;
        logic              rbit;
        logic              special_hit;
        logic              bit_error;
    } sfrsp_rsp_t;

endpackage

// ==== testbench/sfrsp_chk.sv ====
/* Port checker for sfrsp_core.
   Assumes one clock and the bind at the foot of this file. */
`timescale 1ns/1ps
module sfrsp_chk (
    input wire logic                  sys_clk,
    input wire logic                  arst_n,
    input wire sfrsp_pkg::sfrsp_req_t req,
    input wire sfrsp_pkg::sfrsp_rsp_t rsp,
    input wire logic [7:0]            stack_top_pointer,
    input wire logic [7:0]            accumulator_register
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!arst_n);
    // Request steps that the properties build on
    sequence s_push; req.kind == sfrsp_pkg::SFRSP_PUSH; endsequence
    sequence s_pop; req.kind == sfrsp_pkg::SFRSP_POP; endsequence
    sequence s_dwr; req.kind == sfrsp_pkg::SFRSP_DIRECT && req.write;
    endsequence
    property p_ans; req.kind != sfrsp_pkg::SFRSP_NONE |=> rsp.valid;
    endproperty
    property p_idle;
        req.kind == sfrsp_pkg::SFRSP_NONE |=> !rsp.valid
            && $stable(stack_top_pointer);
    endproperty
    // Eight-bit sum so the pointer wraps
    property p_push;
        s_push |=> stack_top_pointer == $past(stack_top_pointer) + 8'h01;
    endproperty
    property p_pop;
        s_pop |=> stack_top_pointer == $past(stack_top_pointer) - 8'h01;
    endproperty
    property p_spwr;
        s_dwr ##0 req.addr == 8'h81 |=> stack_top_pointer == $past(req.wdata);
    endproperty
    property p_accwr;
        s_dwr ##0 req.addr == 8'hE0
            |=> accumulator_register == $past(req.wdata);
    endproperty
    // A bit address next to the pointer must not reach the pointer
    property p_berr;
        req.kind == sfrsp_pkg::SFRSP_BIT && req.addr == 8'h81
            |=> rsp.bit_error && $stable(stack_top_pointer);
    endproperty
    property p_hit;
        req.kind == sfrsp_pkg::SFRSP_DIRECT && req.addr[7] |=> rsp.special_hit;
    endproperty
    property p_ind;
        req.kind == sfrsp_pkg::SFRSP_INDIRECT |=> !rsp.special_hit;
    endproperty
    a_ans: assert property (p_ans) else $error("no answer");
    a_idle: assert property (p_idle) else $error("idle change");
    a_push: assert property (p_push) else $error("push pointer");
    a_pop: assert property (p_pop) else $error("pop pointer");
    a_spwr: assert property (p_spwr) else $error("pointer write");
    a_accwr: assert property (p_accwr) else $error("accum write");
    a_hit: assert property (p_hit) else $error("direct miss");
    a_ind: assert property (p_ind) else $error("indirect hit");
    a_berr: assert property (p_berr) else $error("bit decode");
endmodule // sfrsp_chk

bind sfrsp_core sfrsp_chk i_chk (.sys_clk(sys_clk), .arst_n(arst_n),
    .req(req), .rsp(rsp), .stack_top_pointer(stack_top_pointer),
    .accumulator_register(accumulator_register));

// ==== testbench/sfrsp_exec_model.sv ====
/* Execution logic model that issues one access at a time.
   Assumes the answer arrives one cycle after the request. */
`timescale 1ns/1ps
module sfrsp_exec_model (
    input  wire logic                  sys_clk,
    output sfrsp_pkg::sfrsp_req_t      req,
    input  wire sfrsp_pkg::sfrsp_rsp_t rsp
);
    sfrsp_pkg::sfrsp_rsp_t got;
    initial req = '0;
    task automatic issue(input sfrsp_pkg::sfrsp_kind_t k, input logic w,
        input logic [7:0] a, input logic [7:0] d, input logic b);
        @(negedge sys_clk);
        req = '{k, w, a, d, b};
        @(negedge sys_clk);
        got = rsp;
        // Inverted leftovers so a stale field cannot pass by luck
        req = '{sfrsp_pkg::SFRSP_NONE, ~w, ~a, ~d, ~b};
    endtask
endmodule // sfrsp_exec_model

// ==== testbench/tb_top.sv ====
/* Testbench for sfrsp_core.
   Assumes the checker binds itself and the model drives requests. */
`timescale 1ns/1ps
module tb_top;
    // Short request kinds keep each call on one line with its tag
    localparam sfrsp_pkg::sfrsp_kind_t K_DIR  = sfrsp_pkg::SFRSP_DIRECT;
    localparam sfrsp_pkg::sfrsp_kind_t K_IND  = sfrsp_pkg::SFRSP_INDIRECT;
    localparam sfrsp_pkg::sfrsp_kind_t K_BIT  = sfrsp_pkg::SFRSP_BIT;
    localparam sfrsp_pkg::sfrsp_kind_t K_PUSH = sfrsp_pkg::SFRSP_PUSH;
    localparam sfrsp_pkg::sfrsp_kind_t K_POP  = sfrsp_pkg::SFRSP_POP;
    logic                  sys_clk = 1'b0;
    logic                  arst_n = 1'b0;
    sfrsp_pkg::sfrsp_req_t req;
    sfrsp_pkg::sfrsp_rsp_t rsp;
    logic [7:0]            top_ptr;
    logic [7:0]            accum;
    int                    bad_count = 0;
    int                    n_tests = 0;
    int                    cycles = 0;
    always #50 sys_clk = ~sys_clk;
    sfrsp_core #(.MEM_DEPTH(256)) i_dut (.sys_clk(sys_clk),
        .arst_n(arst_n), .req(req), .rsp(rsp),
        .stack_top_pointer(top_ptr), .accumulator_register(accum));
    sfrsp_exec_model i_exec (.sys_clk(sys_clk), .req(req), .rsp(rsp));
    task automatic chk(input string s, input logic [7:0] e, logic [7:0] g);
        n_tests++;
        if (g !== e) begin
            bad_count++;
            $display("unexpected %s exp %h got %h", s, e, g);
        end
    endtask
    task automatic conclude;
        if (bad_count == 0 && n_tests > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    task automatic t_reset;
        chk("pointer", 8'h07, top_ptr);
        i_exec.issue(K_DIR, 1'b0, 8'h81, 8'h00, 1'b0);
        chk("read", 8'h07, i_exec.got.rdata);
        chk("hit", 8'h01, {7'h00, i_exec.got.special_hit});
    endtask
    task automatic t_stack;
        i_exec.issue(K_PUSH, 1'b1, 8'h00, 8'hA5, 1'b0);
        chk("pointer", 8'h08, top_ptr);
        i_exec.issue(K_IND, 1'b0, 8'h08, 8'h00, 1'b0);
        chk("stacked", 8'hA5, i_exec.got.rdata);
        i_exec.issue(K_POP, 1'b0, 8'h00, 8'h00, 1'b0);
        chk("popped", 8'hA5, i_exec.got.rdata);
        chk("pointer", 8'h07, top_ptr);
    endtask
    // wrap at the top of memory
    task automatic t_wrap;
        i_exec.issue(K_DIR, 1'b1, 8'h81, 8'hFF, 1'b0);
        i_exec.issue(K_PUSH, 1'b1, 8'h00, 8'h3C, 1'b0);
        chk("pointer", 8'h00, top_ptr);
        i_exec.issue(K_IND, 1'b0, 8'h00, 8'h00, 1'b0);
        chk("stacked", 8'h3C, i_exec.got.rdata);
        i_exec.issue(K_POP, 1'b0, 8'h00, 8'h00, 1'b0);
        chk("popped", 8'h3C, i_exec.got.rdata);
        chk("pointer", 8'hFF, top_ptr);
    endtask
    task automatic t_space;
        i_exec.issue(K_IND, 1'b1, 8'h81, 8'h5A, 1'b0);
        i_exec.issue(K_DIR, 1'b0, 8'h81, 8'h00, 1'b0);
        chk("direct", 8'hFF, i_exec.got.rdata);
        i_exec.issue(K_IND, 1'b0, 8'h81, 8'h00, 1'b0);
        chk("upper", 8'h5A, i_exec.got.rdata);
        chk("hit", 8'h00, {7'h00, i_exec.got.special_hit});
        i_exec.issue(K_DIR, 1'b1, 8'hE0, 8'h96, 1'b0);
        chk("accum", 8'h96, accum);
    endtask
    task automatic t_bits;
        i_exec.issue(K_BIT, 1'b1, 8'hE3, 8'h00, 1'b1);
        chk("accum", 8'h9E, accum);
        chk("bit error", 8'h00, {7'h00, i_exec.got.bit_error});
        i_exec.issue(K_BIT, 1'b0, 8'hE4, 8'h00, 1'b0);
        chk("bit", 8'h01, {7'h00, i_exec.got.rbit});
        i_exec.issue(K_BIT, 1'b1, 8'hF1, 8'h00, 1'b1);
        i_exec.issue(K_DIR, 1'b0, 8'hF0, 8'h00, 1'b0);
        chk("b reg", 8'h02, i_exec.got.rdata);
        // Bit 1 of the first row must not reach the pointer beside it
        i_exec.issue(K_BIT, 1'b1, 8'h81, 8'h00, 1'b0);
        chk("pointer", 8'hFF, top_ptr);
        chk("bit error", 8'h01, {7'h00, i_exec.got.bit_error});
    endtask
    // Hang guard
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 1000) begin
            bad_count++;
            conclude();
        end
    end
    initial begin
        repeat (8) @(posedge sys_clk);
        @(negedge sys_clk);
        arst_n = 1'b1;
        t_reset();
        t_stack();
        t_wrap();
        t_space();
        t_bits();
        conclude();
    end
endmodule // tb_top
